// [logic/ctoe_pkg.sv]
// Constants, decode types and the opcode decoder for the tail-opcode execution core.
// Assumes an 8-bit program/data memory with combinational read on the same clock.
// Overview of operation
// - Trap opcode pushes return state, sets mask, loads trap vector; nine cycles.
// - Test subtracts zero from A, X or memory; V cleared, N and Z updated.
// - Wait opcode takes one cycle and clears only the interrupt mask.
// - After wait the core holds its state until an interrupt arrives.
// - Short-offset indexed form fetches one unsigned byte added to the index pair.
// - Long-offset indexed form fetches high then low offset byte, added to index.
// - Absolute form fetches the operand address high byte first, then low.
// - Page-zero form fetches one byte addressing the first memory page.
// - Relative branches add one signed offset byte to the program counter.
// - Post-increment indexed form addresses via index pair, then increments it.
// - Literal form carries the operand value itself after the opcode.
// - Move writes a literal byte to a page-zero address, both in the stream.
package ctoe_pkg;
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] TRAP_VECTOR = 16'hFFFC;
  localparam logic [15:0] IRQ_VECTOR = 16'hFFFA;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'h60;
  localparam int FLAG_V = 7;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int PUSH_LAST = 4;

  localparam logic [7:0] OP_PREFIX = 8'h9E;
  localparam logic [7:0] OP_TRAP = 8'h83;
  localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h84;
  localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h85;
  localparam logic [7:0] OP_ACC_TO_INDEX = 8'h97;
  localparam logic [7:0] OP_INDEX_TO_ACC = 8'h9F;
  localparam logic [7:0] OP_STACK_TO_INDEX = 8'h95;
  localparam logic [7:0] OP_INDEX_TO_STACK = 8'h94;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [7:0] OP_CHECK_PAGE = 8'h3D;
  localparam logic [7:0] OP_CHECK_ACC = 8'h4D;
  localparam logic [7:0] OP_CHECK_INDEX = 8'h5D;
  localparam logic [7:0] OP_CHECK_SHORT = 8'h6D;
  localparam logic [7:0] OP_CHECK_IX = 8'h7D;
  localparam logic [7:0] OP_BRANCH = 8'h20;
  localparam logic [7:0] OP_LOAD_LIT = 8'hA6;
  localparam logic [7:0] OP_LOAD_PAGE = 8'hB6;
  localparam logic [7:0] OP_LOAD_ABS = 8'hC6;
  localparam logic [7:0] OP_LOAD_LONG = 8'hD6;
  localparam logic [7:0] OP_LOAD_SHORT = 8'hE6;
  localparam logic [7:0] OP_LOAD_IX = 8'hF6;
  localparam logic [7:0] OP_MOVE_LIT = 8'h6E;
  localparam logic [7:0] OP_MOVE_POSTINC = 8'h7E;

  typedef enum logic [3:0] {
    MODE_IMPLIED, MODE_LITERAL, MODE_PAGE_ZERO, MODE_ABSOLUTE, MODE_INDEXED,
    MODE_SHORT_IX, MODE_LONG_IX, MODE_STACK_SHORT, MODE_RELATIVE, MODE_POSTINC
  } ctoe_mode_e;

  typedef enum logic [3:0] {
    KIND_NOP, KIND_LOAD, KIND_CHECK_MEM, KIND_CHECK_ACC, KIND_CHECK_INDEX, KIND_BRANCH,
    KIND_MOVE_LIT, KIND_MOVE_POSTINC, KIND_TRAP, KIND_WAIT, KIND_ACC_TO_FLAGS,
    KIND_FLAGS_TO_ACC, KIND_ACC_TO_INDEX, KIND_INDEX_TO_ACC, KIND_STACK_TO_INDEX,
    KIND_INDEX_TO_STACK
  } ctoe_kind_e;

  typedef struct packed {
    ctoe_kind_e kind;
    ctoe_mode_e mode;
    logic [1:0] nbytes;
  } ctoe_dec_s;

  // Unknown opcodes decode as a one-cycle no-operation
  function automatic ctoe_dec_s ctoe_decode(input logic prefix, input logic [7:0] op);
    ctoe_dec_s d;
    d = '{KIND_NOP, MODE_IMPLIED, 2'd0};
    if (prefix) begin
      if (op == OP_CHECK_SHORT) d = '{KIND_CHECK_MEM, MODE_STACK_SHORT, 2'd1};
    end else begin
      unique case (op)
        OP_TRAP: d.kind = KIND_TRAP;
        OP_WAIT: d.kind = KIND_WAIT;
        OP_ACC_TO_FLAGS: d.kind = KIND_ACC_TO_FLAGS;
        OP_FLAGS_TO_ACC: d.kind = KIND_FLAGS_TO_ACC;
        OP_ACC_TO_INDEX: d.kind = KIND_ACC_TO_INDEX;
        OP_INDEX_TO_ACC: d.kind = KIND_INDEX_TO_ACC;
        OP_STACK_TO_INDEX: d.kind = KIND_STACK_TO_INDEX;
        OP_INDEX_TO_STACK: d.kind = KIND_INDEX_TO_STACK;
        OP_CHECK_ACC: d.kind = KIND_CHECK_ACC;
        OP_CHECK_INDEX: d.kind = KIND_CHECK_INDEX;
        OP_CHECK_PAGE: d = '{KIND_CHECK_MEM, MODE_PAGE_ZERO, 2'd1};
        OP_CHECK_SHORT: d = '{KIND_CHECK_MEM, MODE_SHORT_IX, 2'd1};
        OP_CHECK_IX: d = '{KIND_CHECK_MEM, MODE_INDEXED, 2'd0};
        OP_BRANCH: d = '{KIND_BRANCH, MODE_RELATIVE, 2'd1};
        OP_LOAD_LIT: d = '{KIND_LOAD, MODE_LITERAL, 2'd1};
        OP_LOAD_PAGE: d = '{KIND_LOAD, MODE_PAGE_ZERO, 2'd1};
        OP_LOAD_ABS: d = '{KIND_LOAD, MODE_ABSOLUTE, 2'd2};
        OP_LOAD_LONG: d = '{KIND_LOAD, MODE_LONG_IX, 2'd2};
        OP_LOAD_SHORT: d = '{KIND_LOAD, MODE_SHORT_IX, 2'd1};
        OP_LOAD_IX: d = '{KIND_LOAD, MODE_INDEXED, 2'd0};
        OP_MOVE_LIT: d = '{KIND_MOVE_LIT, MODE_PAGE_ZERO, 2'd2};
        OP_MOVE_POSTINC: d = '{KIND_MOVE_POSTINC, MODE_POSTINC, 2'd1};
        default: d.kind = KIND_NOP;
      endcase
    end
    return d;
  endfunction
endpackage

// [logic/ctoe_addr_gen.sv]
// Effective-address former for the tail-opcode execution core.
// Purely combinational; the operand word holds fetched bytes, last byte in the low half.
`timescale 1ns/1ps
`default_nettype none
module ctoe_addr_gen (
  input wire ctoe_pkg::ctoe_mode_e mode_i,
  input wire logic [15:0] index_i,
  input wire logic [15:0] stack_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] operand_i,
  output logic [15:0] addr_o
);
  import ctoe_pkg::*;
  logic [15:0] short_off;
  logic [15:0] signed_off;

  assign short_off = {8'h00, operand_i[7:0]};
  assign signed_off = {{8{operand_i[7]}}, operand_i[7:0]};

  always_comb begin
    unique case (mode_i)
      MODE_PAGE_ZERO: addr_o = short_off;
      MODE_ABSOLUTE: addr_o = operand_i;
      MODE_SHORT_IX: addr_o = index_i + short_off;
      MODE_LONG_IX: addr_o = index_i + operand_i;
      MODE_STACK_SHORT: addr_o = stack_i + short_off;
      MODE_RELATIVE: addr_o = pc_i + signed_off;
      MODE_INDEXED, MODE_POSTINC: addr_o = index_i;
      default: addr_o = pc_i;
    endcase
  end
endmodule
`default_nettype wire

// [logic/ctoe_core.sv]
// Fetch, decode and execute core for the tail group of an 8-bit accumulator CPU.
// Assumes memory answers reads combinationally in the cycle the address is shown,
// and that irq_i comes from interrupt logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ctoe_core (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic irq_i,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic halted_o,
  output logic [7:0] acc_o,
  output logic [15:0] index_o,
  output logic [15:0] sp_o,
  output logic [15:0] pc_o,
  output logic [7:0] flags_o
);
  import ctoe_pkg::*;

  typedef enum logic [6:0] {
    ST_FETCH = 7'b000_0001,
    ST_OPND = 7'b000_0010,
    ST_MEM = 7'b000_0100,
    ST_MEM2 = 7'b000_1000,
    ST_EXTRA = 7'b001_0000,
    ST_PUSH = 7'b010_0000,
    ST_VEC = 7'b100_0000
  } ctoe_state_e;

  ctoe_state_e state;
  ctoe_dec_s dec;
  ctoe_dec_s fetch_dec;
  logic prefix;
  logic waiting;
  logic servicing;
  logic [15:0] vec_base;
  logic [15:0] operand;
  logic [15:0] next_operand;
  logic [1:0] opnd_left;
  logic [2:0] step;
  logic [7:0] hold;
  logic [15:0] ea;
  logic take_irq;
  logic exec_op;
  logic [7:0] acc;
  logic [15:0] index;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [7:0] flags;

  // V cleared, N and Z from the value; carry, half-carry and mask untouched
  function automatic logic [7:0] check_flags(input logic [7:0] f, input logic [7:0] v);
    logic [7:0] r;
    r = f;
    r[FLAG_V] = 1'b0;
    r[FLAG_N] = v[7];
    r[FLAG_Z] = (v == 8'h00);
    return r;
  endfunction

  assign fetch_dec = ctoe_decode(prefix, mem_rdata_i);
  assign take_irq = irq_i && !flags[FLAG_I] && !prefix;
  assign exec_op = (state == ST_FETCH) && !waiting && !take_irq
    && !(!prefix && mem_rdata_i == OP_PREFIX);
  assign next_operand = {operand[7:0], mem_rdata_i};

  ctoe_addr_gen u_addr_gen (
    .mode_i(dec.mode),
    .index_i(index),
    .stack_i(sp),
    .pc_i(pc),
    .operand_i(operand),
    .addr_o(ea)
  );

  // Bus request decode; no access at all while halted
  always_comb begin
    mem_addr_o = pc;
    mem_wdata_o = 8'h00;
    mem_we_o = 1'b0;
    mem_re_o = 1'b0;
    unique case (state)
      ST_FETCH: mem_re_o = !waiting && !take_irq;
      ST_OPND: mem_re_o = 1'b1;
      ST_MEM: begin
        mem_addr_o = ea;
        if (dec.kind == KIND_MOVE_LIT) begin
          mem_we_o = 1'b1;
          mem_wdata_o = operand[15:8];
        end else begin
          mem_re_o = 1'b1;
        end
      end
      ST_MEM2: begin
        mem_addr_o = {8'h00, operand[7:0]};
        mem_we_o = 1'b1;
        mem_wdata_o = hold;
      end
      ST_EXTRA: mem_re_o = 1'b0;
      ST_PUSH: begin
        mem_addr_o = sp;
        mem_we_o = 1'b1;
        unique case (step)
          3'd0: mem_wdata_o = pc[7:0];
          3'd1: mem_wdata_o = pc[15:8];
          3'd2: mem_wdata_o = index[7:0];
          3'd3: mem_wdata_o = acc;
          default: mem_wdata_o = flags;
        endcase
      end
      ST_VEC: begin
        mem_addr_o = vec_base + {15'h0000, step[0]};
        mem_re_o = 1'b1;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_VEC;
      step <= 3'd0;
      opnd_left <= 2'd0;
      prefix <= 1'b0;
      waiting <= 1'b0;
      servicing <= 1'b0;
      vec_base <= RESET_VECTOR;
      dec <= '{KIND_NOP, MODE_IMPLIED, 2'd0};
    end else begin
      unique case (state)
        ST_FETCH: begin
          if (waiting) begin
            // Halted: only an interrupt request restarts the sequencer
            if (irq_i) begin
              waiting <= 1'b0;
              servicing <= 1'b1;
              vec_base <= IRQ_VECTOR;
              state <= ST_EXTRA;
            end
          end else if (take_irq) begin
            servicing <= 1'b1;
            vec_base <= IRQ_VECTOR;
            state <= ST_EXTRA;
          end else if (!prefix && mem_rdata_i == OP_PREFIX) begin
            prefix <= 1'b1;
          end else begin
            prefix <= 1'b0;
            dec <= fetch_dec;
            if (fetch_dec.nbytes != 2'd0) begin
              opnd_left <= fetch_dec.nbytes;
              state <= ST_OPND;
            end else begin
              unique case (fetch_dec.kind)
                KIND_CHECK_MEM, KIND_LOAD, KIND_MOVE_POSTINC: state <= ST_MEM;
                KIND_TRAP: begin
                  vec_base <= TRAP_VECTOR;
                  state <= ST_EXTRA;
                end
                KIND_ACC_TO_FLAGS, KIND_STACK_TO_INDEX, KIND_INDEX_TO_STACK:
                  state <= ST_EXTRA;
                KIND_WAIT: waiting <= 1'b1;
                default: state <= ST_FETCH;
              endcase
            end
          end
        end
        ST_OPND: begin
          opnd_left <= opnd_left - 2'd1;
          if (opnd_left == 2'd1) begin
            unique case (dec.kind)
              KIND_BRANCH: state <= ST_EXTRA;
              KIND_LOAD: state <= (dec.mode == MODE_LITERAL) ? ST_FETCH : ST_MEM;
              default: state <= ST_MEM;
            endcase
          end
        end
        ST_MEM: state <= (dec.kind == KIND_MOVE_POSTINC) ? ST_MEM2 : ST_FETCH;
        ST_MEM2: state <= ST_FETCH;
        ST_EXTRA: begin
          step <= 3'd0;
          if (servicing || dec.kind == KIND_TRAP) begin
            state <= ST_PUSH;
          end else begin
            state <= ST_FETCH;
          end
        end
        ST_PUSH: begin
          step <= step + 3'd1;
          if (step == 3'(PUSH_LAST)) begin
            step <= 3'd0;
            state <= ST_VEC;
          end
        end
        ST_VEC: begin
          step <= step + 3'd1;
          if (step[0]) begin
            step <= 3'd0;
            servicing <= 1'b0;
            dec <= '{KIND_NOP, MODE_IMPLIED, 2'd0};
            state <= ST_FETCH;
          end
        end
      endcase
    end
  end

  // Operand bytes shift in, so a two-byte operand lands high byte first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      operand <= 16'h0000;
      hold <= 8'h00;
    end else begin
      if (state == ST_FETCH) begin
        operand <= 16'h0000;
      end else if (state == ST_OPND) begin
        operand <= next_operand;
      end
      if (state == ST_MEM) begin
        hold <= mem_rdata_i;
      end
    end
  end

  // Program counter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc <= 16'h0000;
    end else begin
      unique case (state)
        ST_FETCH: begin
          if (!waiting && !take_irq) begin
            pc <= pc + 16'h0001;
          end
        end
        ST_OPND: pc <= pc + 16'h0001;
        ST_EXTRA: begin
          if (dec.kind == KIND_BRANCH && !servicing) begin
            pc <= ea;
          end
        end
        ST_VEC: begin
          if (step[0]) begin
            pc[7:0] <= mem_rdata_i;
          end else begin
            pc[15:8] <= mem_rdata_i;
          end
        end
        default: pc <= pc;
      endcase
    end
  end

  // Accumulator and index pair
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc <= 8'h00;
      index <= 16'h0000;
    end else begin
      if (exec_op) begin
        unique case (fetch_dec.kind)
          KIND_FLAGS_TO_ACC: acc <= flags;
          KIND_ACC_TO_INDEX: index[7:0] <= acc;
          KIND_INDEX_TO_ACC: acc <= index[7:0];
          default: acc <= acc;
        endcase
      end
      if (state == ST_OPND && opnd_left == 2'd1 && dec.kind == KIND_LOAD
          && dec.mode == MODE_LITERAL) begin
        acc <= mem_rdata_i;
      end
      if (state == ST_MEM && dec.kind == KIND_LOAD) begin
        acc <= mem_rdata_i;
      end
      if (state == ST_MEM && dec.kind == KIND_MOVE_POSTINC) begin
        index <= index + 16'h0001;
      end
      if (state == ST_EXTRA && !servicing && dec.kind == KIND_STACK_TO_INDEX) begin
        index <= sp + 16'h0001;
      end
    end
  end

  // Stack pointer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp <= SP_RESET;
    end else if (state == ST_PUSH) begin
      sp <= sp - 16'h0001;
    end else if (state == ST_EXTRA && !servicing && dec.kind == KIND_INDEX_TO_STACK) begin
      sp <= index - 16'h0001;
    end
  end

  // Flag register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags <= FLAGS_RESET;
    end else begin
      if (exec_op) begin
        unique case (fetch_dec.kind)
          KIND_CHECK_ACC: flags <= check_flags(flags, acc);
          KIND_CHECK_INDEX: flags <= check_flags(flags, index[7:0]);
          KIND_WAIT: flags[FLAG_I] <= 1'b0;
          default: flags <= flags;
        endcase
      end
      if (state == ST_OPND && opnd_left == 2'd1 && dec.kind == KIND_LOAD
          && dec.mode == MODE_LITERAL) begin
        flags <= check_flags(flags, mem_rdata_i);
      end
      if (state == ST_MEM && (dec.kind == KIND_CHECK_MEM || dec.kind == KIND_LOAD)) begin
        flags <= check_flags(flags, mem_rdata_i);
      end
      if (state == ST_EXTRA && !servicing && dec.kind == KIND_ACC_TO_FLAGS) begin
        // Bits 6 and 5 have no storage and always read as one
        flags <= acc | FLAGS_FIXED_ONES;
      end
      if (state == ST_PUSH && step == 3'(PUSH_LAST)) begin
        flags[FLAG_I] <= 1'b1;
      end
    end
  end

  assign halted_o = waiting;
  assign acc_o = acc;
  assign index_o = index;
  assign sp_o = sp;
  assign pc_o = pc;
  assign flags_o = flags;
endmodule
`default_nettype wire

// [testbench/ctoe_mem_model.sv]
// Behavioural program and data memory for the tail-opcode core bench.
// Assumes one access a cycle with no wait states; the bench preloads the array.
`timescale 1ns/1ps
`default_nettype none
module ctoe_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // Outside reads the bus shows the inverse of the last byte, so stale data never passes
  assign rdata_o = re_i ? mem[addr_i] : ~last;
  always @(posedge clk_i) begin
    if (re_i) last <= mem[addr_i];
    if (we_i) mem[addr_i] <= wdata_i;
  end
endmodule
`default_nettype wire

// [testbench/ctoe_core_sva.sv]
// Checker for the tail-opcode core, bound to its ports.
// Assumes the fetch address equals pc_o during an opcode fetch.
`timescale 1ns/1ps
`default_nettype none
module ctoe_core_sva
  import ctoe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic irq_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_we_o,
  input wire logic mem_re_o,
  input wire logic halted_o,
  input wire logic [7:0] acc_o,
  input wire logic [15:0] index_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Operand bytes equal to an opcode could alias; bench programs avoid that
  sequence s_op(logic [7:0] op);
    mem_re_o && mem_addr_o == pc_o && mem_rdata_i == op;
  endsequence
  sequence s_push;
    mem_we_o [*5];
  endsequence
  property p_trap;
    s_op(OP_TRAP) |=> !mem_re_o && !mem_we_o ##1 s_push ##1 mem_addr_o == TRAP_VECTOR
      ##1 mem_addr_o == TRAP_VECTOR + 16'd1 ##1 flags_o[FLAG_I] && sp_o == $past(sp_o, 9) - 16'd5;
  endproperty
  a_trap: assert property (p_trap) else $error("trap sequence wrong");
  property p_wait;
    s_op(OP_WAIT) |=> halted_o && !flags_o[FLAG_I]
      && {flags_o[7:4], flags_o[2:0]} == {$past(flags_o[7:4]), $past(flags_o[2:0])};
  endproperty
  a_wait: assert property (p_wait) else $error("wait flag update wrong");
  property p_halt;
    halted_o && !irq_i |=> halted_o && !mem_re_o && !mem_we_o && $stable(pc_o) && $stable(acc_o);
  endproperty
  a_halt: assert property (p_halt) else $error("core active while halted");
  property p_wake;
    halted_o && irq_i |=> !halted_o && !mem_re_o && !mem_we_o ##1 s_push
      ##1 mem_re_o && mem_addr_o == IRQ_VECTOR;
  endproperty
  a_wake: assert property (p_wake) else $error("wake sequence wrong");
  property p_acc_to_index;
    s_op(OP_ACC_TO_INDEX) |=> index_o == {$past(index_o[15:8]), $past(acc_o)};
  endproperty
  a_acc_to_index: assert property (p_acc_to_index) else $error("acc to index wrong");
  property p_stack_to_index;
    s_op(OP_STACK_TO_INDEX) |-> ##2 index_o == $past(sp_o, 2) + 16'd1
      && flags_o == $past(flags_o, 2);
  endproperty
  a_stack_to_index: assert property (p_stack_to_index) else $error("stack to index wrong");
  property p_index_to_stack;
    s_op(OP_INDEX_TO_STACK) |-> ##2 sp_o == $past(index_o, 2) - 16'd1;
  endproperty
  a_index_to_stack: assert property (p_index_to_stack) else $error("index to stack wrong");
  property p_short;
    s_op(OP_CHECK_SHORT) ##0 $past(mem_rdata_i) != OP_PREFIX
      |-> ##2 mem_addr_o == $past(index_o, 2) + {8'h00, $past(mem_rdata_i)};
  endproperty
  a_short: assert property (p_short) else $error("short offset address wrong");
  property p_long;
    s_op(OP_LOAD_LONG) |-> ##3 mem_addr_o == $past(index_o, 3)
      + {$past(mem_rdata_i, 2), $past(mem_rdata_i)};
  endproperty
  a_long: assert property (p_long) else $error("long offset address wrong");
  property p_abs;
    s_op(OP_LOAD_ABS) |-> ##3 mem_re_o
      && mem_addr_o == {$past(mem_rdata_i, 2), $past(mem_rdata_i)};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute address wrong");
  property p_branch;
    s_op(OP_BRANCH) |-> ##3 pc_o == $past(pc_o, 3) + 16'd2 + 16'($signed($past(mem_rdata_i, 2)));
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
endmodule
bind ctoe_core ctoe_core_sva u_ctoe_core_sva (.clk_i, .rstn_i, .mem_rdata_i, .irq_i,
  .mem_addr_o, .mem_we_o, .mem_re_o, .halted_o, .acc_o, .index_o, .sp_o, .pc_o, .flags_o);
`default_nettype wire

// [testbench/ctoe_core_tb.sv]
// Self-checking bench for the tail-opcode core: one preloaded program, walked fetch by fetch.
// Assumes the memory model answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none
module ctoe_core_tb;
  import ctoe_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic irq_i = 1'b0;
  logic [7:0] mem_rdata_i, mem_wdata_o, acc_o, flags_o;
  logic [15:0] mem_addr_o, index_o, sp_o, pc_o;
  logic mem_we_o, mem_re_o, halted_o;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  ctoe_core u_ctoe_core (.clk_i, .rstn_i, .mem_rdata_i, .irq_i, .mem_addr_o, .mem_wdata_o,
    .mem_we_o, .mem_re_o, .halted_o, .acc_o, .index_o, .sp_o, .pc_o, .flags_o);
  ctoe_mem_model u_ctoe_mem_model (.clk_i, .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .we_i(mem_we_o), .re_i(mem_re_o), .rdata_o(mem_rdata_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Waits for the opcode fetch at a; n checks the cycles of the instruction just ended
  task automatic step(input logic [15:0] a, input int n);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_i);
      if (mem_re_o === 1'b1 && mem_addr_o === a) break;
    end
    if (i == 60) begin
      error_cnt++;
      $display("unexpected at %0t: no fetch at %h", $time, a);
      end_sim();
    end else begin
      if (n > 0) chk(16'(cyc - last), 16'(n));
      last = cyc;
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) u_ctoe_mem_model.mem[a + 16'(i)] = b[i];
  endtask
  function automatic logic [7:0] rd(input logic [15:0] a);
    return u_ctoe_mem_model.mem[a];
  endfunction
  task automatic s_reset();
    repeat (2) @(negedge clk_i);
    chk(sp_o, SP_RESET);
    chk(16'(flags_o), 16'(FLAGS_RESET));
    chk(mem_addr_o, RESET_VECTOR);
    rstn_i = 1'b1;
    step(16'h0100, 0);
  endtask
  task automatic s_xfer();
    step(16'h0102, 2);
    chk(16'(acc_o), 16'h0080);
    step(16'h0103, 1);
    chk(index_o, 16'h0080);
    step(16'h0104, 1);
    chk(16'(acc_o), 16'h006C);
    step(16'h0105, 1);
    chk(16'(acc_o), 16'h0080);
    step(16'h0107, 2);
    step(16'h0108, 2);
    chk(16'(flags_o), 16'h0063);
    step(16'h0109, 1);
    chk(16'(flags_o), 16'h0061);
    step(16'h010A, 2);
    chk(index_o, 16'h0100);
    step(16'h010B, 1);
    step(16'h010C, 2);
    chk(sp_o, 16'h0102);
    chk(16'(flags_o), 16'h0061);
  endtask
  task automatic s_check();
    step(16'h010E, 3);
    chk(16'(flags_o), 16'h0065);
    step(16'h0110, 3);
    chk(16'(flags_o), 16'h0063);
    step(16'h0111, 2);
    chk(16'(flags_o), 16'h0065);
    step(16'h0114, 4);
    chk(16'(flags_o), 16'h0063);
    chk(16'(acc_o), 16'h0003);
  endtask
  task automatic s_modes();
    step(16'h0117, 4);
    chk(16'(acc_o), 16'h005A);
    step(16'h011A, 4);
    chk(16'(acc_o), 16'h00C3);
    step(16'h011C, 3);
    chk(16'(acc_o), 16'h0000);
    step(16'h011F, 4);
    chk(16'(rd(16'h0050)), 16'h0077);
    step(16'h0121, 4);
    chk(16'(rd(16'h0051)), 16'h0085);
    chk(index_o, 16'h0104);
    step(16'h0133, 3);
    step(16'h0125, 3);
  endtask
  task automatic s_trap_wait();
    step(16'h0140, 9);
    chk({rd(16'h0102), rd(16'h0101)}, 16'h2601);
    chk({rd(16'h0100), rd(16'h00FF)}, 16'h0400);
    chk(sp_o, 16'h00FD);
    chk(16'(flags_o[FLAG_I]), 16'h0001);
    repeat (4) @(negedge clk_i);
    chk(16'(flags_o[FLAG_I]), 16'h0000);
    chk({13'h0000, halted_o, mem_re_o, mem_we_o}, 16'h0004);
    chk(pc_o, 16'h0141);
    last = cyc;
    irq_i = 1'b1;
    step(16'h0150, 9);
    irq_i = 1'b0;
    chk({rd(16'h00FD), rd(16'h00FC)}, 16'h4101);
    chk(16'(halted_o), 16'h0000);
  endtask
  // Index-low test, short-offset load, then an interrupt taken while running
  task automatic s_tail();
    step(16'h0151, 1);
    chk(16'(flags_o), 16'h0069);
    step(16'h0153, 3);
    chk(16'(acc_o), 16'h005A);
    step(16'h0155, 2);
    chk(16'(flags_o), 16'h006B);
    step(16'h0156, 2);
    chk(16'(flags_o), 16'h0060);
    irq_i = 1'b1;
    step(16'h0150, 9);
    irq_i = 1'b0;
    chk({rd(16'h00F7), rd(16'h00F8)}, 16'h0156);
    chk(sp_o, 16'h00F3);
    chk(16'(flags_o[FLAG_I]), 16'h0001);
  endtask
  initial begin
    for (int i = 0; i < 65536; i++) u_ctoe_mem_model.mem[i] = 8'h9D;
    put(16'h0100, {8'hA6, 8'h80, 8'h97, 8'h85, 8'h9F, 8'hA6, 8'h03, 8'h84, 8'h4D, 8'h95,
      8'h97, 8'h94, 8'h3D, 8'h40, 8'h6D, 8'hFE, 8'h7D, 8'h9E, 8'h6D, 8'hFF, 8'hC6, 8'h02,
      8'h00, 8'hD6, 8'h01, 8'h00, 8'hB6, 8'h41, 8'h6E, 8'h77, 8'h50, 8'h7E, 8'h51, 8'h20,
      8'h10});
    put(16'h0133, {8'h20, 8'hF0});
    put(16'h0125, {8'h83});
    put(16'h0140, {8'h8F});
    put(16'h0150, {8'h5D, 8'hE6, 8'hFC, 8'hA6, 8'h00, 8'h84});
    put(16'h0040, {8'h80, 8'h00});
    put(16'h0200, {8'h5A, 8'h00, 8'h9D, 8'hC3});
    put(16'hFFFA, {8'h01, 8'h50, 8'h01, 8'h40, 8'h01, 8'h00});
    s_reset();
    s_xfer();
    s_check();
    s_modes();
    s_trap_wait();
    s_tail();
    end_sim();
  end
endmodule
`default_nettype wire
